// [src/wsme_encoder.sv]
`timescale 1ns/10ps
`include "wsme_consts.svh"
module wsme_encoder
    import wsme_pkg::*;
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // message request from the pulse generator
    input wire logic i_msg_req,
    input wire logic i_msg_standstill,
    output logic o_req_ready,
    // per-message fields from the sensing path
    input wire logic i_air_gap_reserve,
    input wire logic i_direction_valid,
    input wire logic i_rotation_dir,
    input wire logic i_calibration,
    input wire logic [2:0] i_chan_code,
    input wire logic [2:0] i_pkpk_code,
    input wire logic [2:0] i_temp_code,
    // events
    input wire logic i_overtemp,
    input wire logic i_eeprom_write_needed,
    input wire logic i_write_count_exceeded,
    // word towards the current modulator
    output logic o_word_valid,
    output logic [`WSME_WORD_W-1:0] o_word,
    output logic o_pulse_kind_level,
    input wire logic i_word_ready,
    // status
    output logic o_selfwrite_start,
    output logic o_overtemp_flag,
    output logic o_eeprom_write_flag
);
    wsme_word_if #(.W(`WSME_ENT_W)) enc_if();
    wsme_word_if #(.W(`WSME_ENT_W)) out_if();

    ////////////////////////////////////////////////////////////////////
    // state
    wsme_slot_t slot_reg, slot_next;
    logic ot_reg, ot_next;
    logic ee_reg, ee_next;
    logic [1:0] ee_cnt_reg, ee_cnt_next;
    wsme_ee_e ee_st_reg, ee_st_next;
    logic start_reg, start_next;

    logic accept, tag;
    wsme_mean_t mean;
    wsme_data_t data;
    logic [`WSME_WORD_W-1:0] word;

    ////////////////////////////////////////////////////////////////////
    // word selection
    always_comb begin
        accept = i_msg_req & enc_if.ready;
        mean = `WSME_MEAN_CHAN;
        data = i_chan_code;
        tag = 1'b0;
        if (i_calibration) begin
            mean = `WSME_MEAN_CHAN;
            data = i_chan_code;
        end else if (i_msg_standstill && ee_reg &&
                     ee_st_reg != WSME_EE_EXCEEDED) begin
            mean = `WSME_MEAN_SPECIAL;
            data = `WSME_SPC_WRITE_REQ;
            tag = (ee_cnt_reg == `WSME_EE_REPEAT - 2'h1);
        end else if (i_msg_standstill && ee_reg) begin
            mean = `WSME_MEAN_SPECIAL;
            data = `WSME_SPC_CNT_EXCEEDED;
        end else if (slot_reg == `WSME_SEQ_PKPK_SLOT) begin
            mean = `WSME_MEAN_PKPK;
            data = i_pkpk_code;
        end else if (slot_reg == `WSME_SEQ_TEMP_SLOT) begin
            if (ot_reg) begin
                mean = `WSME_MEAN_SPECIAL;
                data = `WSME_SPC_OVERTEMP;
            end else begin
                mean = `WSME_MEAN_TEMP;
                data = i_temp_code;
            end
        end else begin
            mean = `WSME_MEAN_CHAN;
            data = i_chan_code;
        end
    end

    wsme_word_asm u_asm (
        .i_air_gap_reserve(i_air_gap_reserve),
        .i_mean(mean),
        // caller sets validity by message type
        .i_direction_valid(i_direction_valid),
        .i_rotation_dir(i_rotation_dir),
        .i_data(data),
        .o_word(word)
    );

    // kind bit picks high or middle level
    assign enc_if.data = {tag, ~i_msg_standstill, word};
    assign enc_if.valid = i_msg_req;

    wsme_buf2 #(.W(`WSME_ENT_W)) u_buf (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .in_if(enc_if),
        .out_if(out_if)
    );
    assign out_if.ready = i_word_ready;

    ////////////////////////////////////////////////////////////////////
    // flags and sequence
    always_comb begin
        slot_next = slot_reg;
        ot_next = ot_reg;
        ee_next = ee_reg;
        ee_cnt_next = ee_cnt_reg;
        ee_st_next = ee_st_reg;
        if (accept && !i_calibration) begin
            slot_next = (slot_reg == `WSME_SEQ_TEMP_SLOT) ?
                        `WSME_SEQ_FIRST : slot_reg + 5'h01;
        end
        if (accept && !i_calibration && ot_reg &&
            slot_reg == `WSME_SEQ_TEMP_SLOT && !(i_msg_standstill &&
            ee_reg)) begin
            ot_next = 1'b0;
        end
        if (i_overtemp) begin
            ot_next = 1'b1;
        end
        if (accept && !i_calibration && ee_reg) begin
            if (!i_msg_standstill) begin
                ee_cnt_next = 2'h0;
            end else if (ee_st_reg == WSME_EE_EXCEEDED) begin
                ee_next = 1'b0;
                ee_st_next = WSME_EE_IDLE;
            end else if (ee_cnt_reg == `WSME_EE_REPEAT - 2'h1) begin
                ee_next = 1'b0;
                ee_cnt_next = 2'h0;
                ee_st_next = WSME_EE_IDLE;
            end else begin
                ee_cnt_next = ee_cnt_reg + 2'h1;
                ee_st_next = WSME_EE_SENDING;
            end
        end
        if (i_eeprom_write_needed) begin
            ee_next = 1'b1;
            if (!ee_reg) begin
                ee_cnt_next = 2'h0;
                ee_st_next = i_write_count_exceeded ?
                             WSME_EE_EXCEEDED : WSME_EE_IDLE;
            end
        end
    end

    // start when third word leaves buffer
    always_comb begin
        start_next = out_if.valid & out_if.ready &
                     out_if.data[`WSME_ENT_TAG];
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            slot_reg <= `WSME_SEQ_FIRST;
            ot_reg <= 1'b0;
            ee_reg <= 1'b0;
            ee_cnt_reg <= 2'h0;
            ee_st_reg <= WSME_EE_IDLE;
            start_reg <= 1'b0;
        end else begin
            slot_reg <= slot_next;
            ot_reg <= ot_next;
            ee_reg <= ee_next;
            ee_cnt_reg <= ee_cnt_next;
            ee_st_reg <= ee_st_next;
            start_reg <= start_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs, all from flops
    assign o_req_ready = enc_if.ready;
    assign o_word_valid = out_if.valid;
    assign o_word = out_if.data[`WSME_WORD_W-1:0];
    assign o_pulse_kind_level = out_if.data[`WSME_ENT_KIND];
    assign o_selfwrite_start = start_reg;
    assign o_overtemp_flag = ot_reg;
    assign o_eeprom_write_flag = ee_reg;
endmodule

// [src/wsme_consts.svh]
`ifndef WSME_CONSTS_SVH
`define WSME_CONSTS_SVH

// word field positions
`define WSME_BIT_AIR_GAP 0
`define WSME_BIT_MEAN_LO 1
`define WSME_BIT_MEAN_HI 2
`define WSME_BIT_DIR_VALID 3
`define WSME_BIT_ROT_DIR 4
`define WSME_BIT_DATA_LO 5
`define WSME_BIT_DATA_HI 7
`define WSME_BIT_PARITY 8
`define WSME_WORD_W 9

// meaning codes, numeric with bit 1 as lsb
`define WSME_MEAN_PKPK 2'h0
`define WSME_MEAN_CHAN 2'h1
`define WSME_MEAN_SPECIAL 2'h2
`define WSME_MEAN_TEMP 2'h3

// special event data codes, numeric with bit 5 as lsb
`define WSME_SPC_LOCKOUT 3'h0
`define WSME_SPC_CNT_EXCEEDED 3'h1
`define WSME_SPC_WRITE_REQ 3'h2
`define WSME_SPC_OVERTEMP 3'h4

// additional word sequence
`define WSME_SEQ_PKPK_SLOT 5'h09
`define WSME_SEQ_TEMP_SLOT 5'h13
`define WSME_SEQ_FIRST 5'h00
`define WSME_EE_REPEAT 2'h3

// buffer entry layout
`define WSME_ENT_W 11
`define WSME_ENT_KIND 9
`define WSME_ENT_TAG 10

`endif

// [src/wsme_pkg.sv]
package wsme_pkg;
    typedef logic [4:0] wsme_slot_t;
    typedef logic [1:0] wsme_mean_t;
    typedef logic [2:0] wsme_data_t;
    typedef enum logic [1:0] {
        WSME_EE_IDLE = 2'b00,
        WSME_EE_SENDING = 2'b01,
        WSME_EE_EXCEEDED = 2'b10
    } wsme_ee_e;
endpackage

// [src/wsme_word_if.sv]
`timescale 1ns/10ps
interface wsme_word_if #(parameter int W = 11);
    logic [W-1:0] data;
    logic valid;
    logic ready;
    modport src(output data, output valid, input ready);
    modport snk(input data, input valid, output ready);
endinterface

// [src/wsme_word_asm.sv]
`timescale 1ns/10ps
`include "wsme_consts.svh"
module wsme_word_asm
    import wsme_pkg::*;
(
    // fields
    input wire logic i_air_gap_reserve,
    input wire wsme_mean_t i_mean,
    input wire logic i_direction_valid,
    input wire logic i_rotation_dir,
    input wire wsme_data_t i_data,
    // word
    output logic [`WSME_WORD_W-1:0] o_word
);
    always_comb begin
        o_word = '0;
        o_word[`WSME_BIT_AIR_GAP] = i_air_gap_reserve;
        o_word[`WSME_BIT_MEAN_HI:`WSME_BIT_MEAN_LO] = i_mean;
        o_word[`WSME_BIT_DIR_VALID] = i_direction_valid;
        o_word[`WSME_BIT_ROT_DIR] = i_rotation_dir;
        o_word[`WSME_BIT_DATA_HI:`WSME_BIT_DATA_LO] = i_data;
        o_word[`WSME_BIT_PARITY] = ^o_word[`WSME_BIT_PARITY-1:0];
    end
endmodule

// [src/wsme_buf2.sv]
`timescale 1ns/10ps
module wsme_buf2 #(
    parameter int W = 11
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // fill and drain sides
    wsme_word_if.snk in_if,
    wsme_word_if.src out_if
);
    logic [W-1:0] head_reg, head_next, tail_reg, tail_next;
    logic head_v_reg, head_v_next, tail_v_reg, tail_v_next;
    logic push, pop;

    // head is always the oldest entry, so output comes from flops
    assign in_if.ready = ~tail_v_reg;
    assign out_if.data = head_reg;
    assign out_if.valid = head_v_reg;

    always_comb begin
        push = in_if.valid & ~tail_v_reg;
        pop = head_v_reg & out_if.ready;
        head_next = head_reg;
        tail_next = tail_reg;
        head_v_next = head_v_reg;
        tail_v_next = tail_v_reg;
        if (!head_v_reg || pop) begin
            if (tail_v_reg) begin
                head_next = tail_reg;
                head_v_next = 1'b1;
                tail_next = in_if.data;
                tail_v_next = push;
            end else begin
                head_next = in_if.data;
                head_v_next = push;
            end
        end else if (push) begin
            tail_next = in_if.data;
            tail_v_next = 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            head_reg <= '0;
            tail_reg <= '0;
            head_v_reg <= 1'b0;
            tail_v_reg <= 1'b0;
        end else begin
            head_reg <= head_next;
            tail_reg <= tail_next;
            head_v_reg <= head_v_next;
            tail_v_reg <= tail_v_next;
        end
    end
endmodule

// [verification/wsme_enc_properties.sv]
`timescale 1ns/10ps
`include "wsme_consts.svh"
module wsme_enc_chk (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // request side
    input wire logic i_msg_req,
    input wire logic i_msg_standstill,
    input wire logic o_req_ready,
    input wire logic i_air_gap_reserve,
    input wire logic i_direction_valid,
    input wire logic i_rotation_dir,
    input wire logic i_calibration,
    input wire logic [2:0] i_chan_code,
    input wire logic i_overtemp,
    input wire logic i_eeprom_write_needed,
    // word side and status
    input wire logic o_word_valid,
    input wire logic [`WSME_WORD_W-1:0] o_word,
    input wire logic o_pulse_kind_level,
    input wire logic i_word_ready,
    input wire logic o_selfwrite_start,
    input wire logic o_overtemp_flag,
    input wire logic o_eeprom_write_flag
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    // empty buffer: the new word is at the head next cycle
    logic take0;
    logic out;
    assign take0 = i_msg_req && o_req_ready && !o_word_valid;
    assign out = o_word_valid && i_word_ready;
    ////////////////////////////////////////////////////////////////
    AST_PARITY: assert property (o_word_valid |-> !(^o_word))
        else $error("word parity odd");
    AST_HOLD: assert property (o_word_valid && !i_word_ready |=>
        o_word_valid && $stable(o_word) && $stable(o_pulse_kind_level))
        else $error("word changed while stalled");
    AST_LEVEL: assert property (take0 |=> o_word_valid &&
        o_pulse_kind_level == !$past(i_msg_standstill))
        else $error("pulse level wrong");
    AST_FIELDS: assert property (take0 |=>
        o_word[0] == $past(i_air_gap_reserve) &&
        o_word[3] == $past(i_direction_valid) &&
        o_word[4] == $past(i_rotation_dir))
        else $error("loose bits wrong");
    AST_CALIB: assert property (take0 && i_calibration |=>
        o_word[2:1] == `WSME_MEAN_CHAN && o_word[7:5] == $past(i_chan_code))
        else $error("calibration word not channel");
    AST_OT_SET: assert property (i_overtemp |=> o_overtemp_flag)
        else $error("overtemp flag not set");
    AST_OT_CLR: assert property ($fell(o_overtemp_flag) |->
        $past(i_msg_req && o_req_ready && !i_calibration && !i_overtemp))
        else $error("overtemp flag cleared without word");
    AST_EE_SET: assert property (i_eeprom_write_needed &&
        !o_eeprom_write_flag |=> o_eeprom_write_flag)
        else $error("write flag not set");
    AST_SW_PULSE: assert property (o_selfwrite_start |->
        $past(out && !o_pulse_kind_level &&
        o_word[7:5] == `WSME_SPC_WRITE_REQ) ##1 !o_selfwrite_start)
        else $error("self-write start misplaced");
    cover property (o_selfwrite_start);
    cover property (o_word_valid && !i_word_ready && !o_req_ready);
    cover property ($fell(o_overtemp_flag));
endmodule

bind wsme_encoder wsme_enc_chk u_chk (.*);

// [verification/wsme_ctrl_model.sv]
`timescale 1ns/10ps
module wsme_ctrl_model (
    // clock, reset, stall request
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_stall,
    // word from the encoder
    input wire logic i_word_valid,
    input wire logic [8:0] i_word,
    input wire logic i_level,
    output logic o_ready
);
    logic [9:0] rx_q[$];
    initial o_ready = 1'b0;
    // ready only moves off the sampling edge
    always @(negedge i_sys_clk) o_ready <= !i_stall && !i_rst;
    always @(posedge i_sys_clk) begin
        if (!i_rst && i_word_valid && o_ready)
            rx_q.push_back({i_level, i_word});
    end
endmodule

// [verification/wsme_encoder_bench.sv]
`timescale 1ns/10ps
`include "wsme_consts.svh"
module wsme_encoder_bench;
    logic i_sys_clk, i_rst, i_msg_req, i_msg_standstill, o_req_ready;
    logic i_air_gap_reserve, i_direction_valid, i_rotation_dir;
    logic i_calibration, i_overtemp, i_eeprom_write_needed;
    logic i_write_count_exceeded, o_word_valid, o_pulse_kind_level;
    logic i_word_ready, o_selfwrite_start, o_overtemp_flag;
    logic o_eeprom_write_flag, stall, ot, ee_on, ee_exc;
    logic [2:0] i_chan_code, i_pkpk_code, i_temp_code;
    logic [`WSME_WORD_W-1:0] o_word;
    logic [9:0] exp_q[$];
    int num_errors, checks, slot, ee_cnt, cyc, sw_cnt;

    initial begin
        i_sys_clk = 0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end
    wsme_encoder u_dut (.*);
    wsme_ctrl_model u_model (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
        .i_stall(stall), .i_word_valid(o_word_valid), .i_word(o_word),
        .i_level(o_pulse_kind_level), .o_ready(i_word_ready));
    always @(posedge i_sys_clk) begin
        cyc++;
        if (o_selfwrite_start === 1'b1) sw_cnt++;
        if (cyc == 5000) begin
            num_errors++;
            wrap_up;
        end
    end
    ////////////////////////////////////////////////////////////////
    task wrap_up;
        if (num_errors == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task check(input logic [9:0] seen, input logic [9:0] want);
        checks++;
        if (seen !== want) begin
            num_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    function automatic logic [9:0] mk(logic lvl, logic [1:0] m,
        logic [2:0] d);
        logic [7:0] w;
        w = {d, i_rotation_dir, i_direction_valid, m, i_air_gap_reserve};
        return {lvl, ^w, w};
    endfunction
    // one request, expectation from slot and flag state
    task automatic msg(input logic ss);
        logic [1:0] m;
        logic [2:0] d;
        m = `WSME_MEAN_CHAN;
        d = i_chan_code;
        if (!i_calibration) begin
            if (ss && ee_on) begin
                m = `WSME_MEAN_SPECIAL;
                d = ee_exc ? `WSME_SPC_CNT_EXCEEDED : `WSME_SPC_WRITE_REQ;
                ee_cnt++;
                if (ee_exc || ee_cnt == 3) ee_on = 0;
            end else if (slot == 19) begin
                m = ot ? `WSME_MEAN_SPECIAL : `WSME_MEAN_TEMP;
                d = ot ? `WSME_SPC_OVERTEMP : i_temp_code;
            end else if (slot == 9) begin
                m = `WSME_MEAN_PKPK;
                d = i_pkpk_code;
            end
            if (!ss) ee_cnt = 0;
            slot = (slot == 19) ? 0 : slot + 1;
        end
        exp_q.push_back(mk(!ss, m, d));
        i_msg_standstill = ss;
        i_msg_req = 1;
        while (o_req_ready !== 1'b1) @(negedge i_sys_clk);
        @(negedge i_sys_clk);
    endtask
    task flush;
        i_msg_req = 0;
        for (int n = 0; n < 50 && u_model.rx_q.size() != exp_q.size(); n++)
            @(negedge i_sys_clk);
        check(10'(u_model.rx_q.size()), 10'(exp_q.size()));
        foreach (exp_q[k]) check(u_model.rx_q[k], exp_q[k]);
        exp_q.delete();
        u_model.rx_q.delete();
        @(negedge i_sys_clk);
    endtask
    // twenty speed words, optionally with the receiver stalling
    task automatic round(input logic st);
        fork
            for (int i = 0; i < 20; i++) begin
                {i_rotation_dir, i_direction_valid, i_air_gap_reserve} = 3'(i);
                msg(0);
            end
            if (st) begin
                stall <= 1;
                repeat (8) @(negedge i_sys_clk);
                stall <= 0;
            end
        join
        flush;
    endtask
    task pulse_ee;
        i_eeprom_write_needed = 1;
        ee_on = 1;
        @(negedge i_sys_clk);
        i_eeprom_write_needed = 0;
        check(10'(o_eeprom_write_flag), 10'h001);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        {i_rst, i_msg_req, i_msg_standstill, i_air_gap_reserve} = 4'h8;
        {i_direction_valid, i_rotation_dir, i_calibration} = 3'h0;
        {i_overtemp, i_eeprom_write_needed, i_write_count_exceeded} = 3'h0;
        {i_chan_code, i_pkpk_code, i_temp_code} = {3'h4, 3'h6, 3'h3};
        {stall, ot, ee_on, ee_exc} = 4'h0;
        {num_errors, checks, slot, ee_cnt, cyc, sw_cnt} = '0;
        repeat (10) @(negedge i_sys_clk);
        i_rst = 0;
        check({o_word_valid, o_word}, 10'h000);
        check(10'({o_req_ready, o_overtemp_flag}), 10'h002);
        round(1);
        i_overtemp = 1;
        ot = 1;
        @(negedge i_sys_clk);
        round(0);
        i_overtemp = 0;
        check(10'(o_overtemp_flag), 10'h001);
        round(0);
        ot = 0;
        check(10'(o_overtemp_flag), 10'h000);
        round(0);
        i_calibration = 1;
        msg(0);
        msg(1);
        flush;
        i_calibration = 0;
        pulse_ee;
        msg(1);
        msg(1);
        msg(0);
        flush;
        check(10'(sw_cnt), 10'h000);
        repeat (3) msg(1);
        msg(1);
        msg(0);
        flush;
        check(10'(sw_cnt), 10'h001);
        check(10'(o_eeprom_write_flag), 10'h000);
        i_write_count_exceeded = 1;
        ee_exc = 1;
        pulse_ee;
        msg(1);
        msg(1);
        flush;
        check(10'({sw_cnt[1:0], o_eeprom_write_flag}), 10'h002);
        wrap_up;
    end
endmodule
